// ---- ctrl_regs_pkg.sv ----
// package for the control register window: map, field layout, reset values, carriers.
// assumes a 32-bit APB master; byte address = 4 * data-memory address.
package ctrl_regs_pkg;

    // control register window in data memory (banks 56..63)
    localparam logic [13:0] WINDOW_LOW       = 14'h3800;
    localparam logic [13:0] WINDOW_HIGH      = 14'h3FFF;
    localparam int          BANK_FIRST       = 56;
    // register locations within data memory, chosen inside the window
    localparam logic [13:0] EXEC_STATE_INDEX = 14'h3FF0;
    localparam logic [13:0] T5_FLAGS_INDEX   = 14'h3FF1;
    // test-event register: software may raise flags for bring-up
    localparam logic [13:0] T5_FORCE_INDEX   = 14'h3FF2;
    localparam int          ADDR_WIDTH       = 16;

    // field positions
    localparam int STATE_HI_POS   = 7;
    localparam int STATE_LO_POS   = 6;
    localparam int GATE_FLAG_POS  = 7;
    localparam int COUNT_FLAG_POS = 6;

    // reset values
    localparam logic [1:0] STATE_RESET = 2'h0;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // execution context, gray coded along main -> low -> high-from-low
    typedef enum logic [1:0] {
        CTX_MAIN      = 2'b00,
        CTX_LOW       = 2'b01,
        CTX_HIGH_LOW  = 2'b11,
        CTX_HIGH_MAIN = 2'b10
    } ctx_type;

    typedef struct packed {
        logic high_entry;
        logic low_entry;
        logic handler_return;
    } ctx_event_type;

    typedef struct packed {
        logic gate_event;
        logic count_event;
    } t5_event_type;

endpackage

// ---- exec_state_tracker.sv ----
// tracks which execution context the cpu is in, from entry and return pulses.
// assumes one event pulse per cycle at most; core only enters legal handlers.
`timescale 1ns/1ps

module exec_state_tracker
    import ctrl_regs_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire ctrl_regs_pkg::ctx_event_type ev,
    output ctrl_regs_pkg::ctx_type            ctx
);
    import ctrl_regs_pkg::*;

    ctx_type state_r;
    ctx_type state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CTX_MAIN: begin
                if (ev.high_entry) begin
                    state_nxt = CTX_HIGH_MAIN;
                end else if (ev.low_entry) begin
                    state_nxt = CTX_LOW;
                end
            end
            CTX_LOW: begin
                if (ev.high_entry) begin
                    state_nxt = CTX_HIGH_LOW;
                end else if (ev.handler_return) begin
                    state_nxt = CTX_MAIN;
                end
            end
            CTX_HIGH_LOW: begin
                // returning from high falls back into the preempted low handler
                if (ev.handler_return) begin
                    state_nxt = CTX_LOW;
                end
            end
            CTX_HIGH_MAIN: begin
                if (ev.handler_return) begin
                    state_nxt = CTX_MAIN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ctx_type'(STATE_RESET);
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ctx = state_r;

endmodule

// ---- interrupt_state_and_flag_regs.sv ----
// apb slave for the execution-state status and timer-5 event flag registers.
// assumes the core pulses context events and timer 5 pulses its events on clk.
//
// How it works
// - registers live in window 3800h to 3FFFh
// - flag bits clear where a write has 0 unless an event sets them in that cycle, keep their value where it has 1
// - unassigned window addresses read all zeros
// - two-bit read-only state field, reset zero
// - high handler reads 11 or 10
// - low handler reads 01, main 00
// - low six bits read zero
// - gate flag bit 7 sticky until cleared
// - count flag bit 6 sticky until cleared
// - flags set regardless of any enable
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module interrupt_state_and_flag_regs
    import ctrl_regs_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ctrl_regs_pkg::ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire ctrl_regs_pkg::ctx_event_type ctx_event,
    input  wire ctrl_regs_pkg::t5_event_type  t5_event,
    output ctrl_regs_pkg::ctx_type            exec_state,
    output logic                              timer5_gate_event_flag,
    output logic                              timer5_count_event_flag
);
    import ctrl_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [13:0] word_index;
    logic        in_window;
    logic        hit_state;
    logic        hit_flags;
    logic        hit_force;
    logic        wr_access;

    assign word_index = paddr[15:2];
    assign in_window  = (word_index >= WINDOW_LOW) && (word_index <= WINDOW_HIGH);
    assign hit_state  = in_window && (word_index == EXEC_STATE_INDEX);
    assign hit_flags  = in_window && (word_index == T5_FLAGS_INDEX);
    assign hit_force  = in_window && (word_index == T5_FORCE_INDEX);
    // writes take effect only in the access phase; single-cycle answer
    assign wr_access  = psel && penable && pwrite && pstrb[0];
    assign pready     = 1'b1;
    // outside the window is not our space: flag it rather than alias
    assign pslverr    = psel && penable && !in_window;

    ////////////////////////////////////////////////////////////////////////////
    // execution context

    exec_state_tracker u_tracker (
        .clk    (clk),
        .resetn (resetn),
        .ev     (ctx_event),
        .ctx    (exec_state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // timer-5 event flags

    logic [1:0] flags_r;
    logic [1:0] flags_nxt;
    logic [1:0] hw_set;
    logic [1:0] sw_clear;
    logic [1:0] sw_force;

    // no enable input exists here on purpose: flags record every event
    assign hw_set   = {t5_event.gate_event, t5_event.count_event};
    assign sw_clear = (wr_access && hit_flags) ?
                      ~pwdata[GATE_FLAG_POS:COUNT_FLAG_POS] : 2'h0;
    assign sw_force = (wr_access && hit_force) ?
                      pwdata[GATE_FLAG_POS:COUNT_FLAG_POS] : 2'h0;

    always_comb begin
        flags_nxt = flags_r;
        for (int i = 0; i < 2; i++) begin
            if (hw_set[i] || sw_force[i]) begin
                flags_nxt[i] = 1'b1;
            end else if (sw_clear[i]) begin
                flags_nxt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign timer5_gate_event_flag  = flags_r[1];
    assign timer5_count_event_flag = flags_r[0];

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered so prdata comes from flip-flops

    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    always_comb begin
        rdata_nxt = {24'h000000, UNMAPPED_READ};
        if (psel && !penable && !pwrite) begin
            if (hit_state) begin
                rdata_nxt[STATE_HI_POS:STATE_LO_POS] = exec_state;
            end else if (hit_flags) begin
                rdata_nxt[GATE_FLAG_POS:COUNT_FLAG_POS] = flags_r;
            end
        end else begin
            rdata_nxt = rdata_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // flag captured at setup; an event arriving in the access cycle shows next read
    assign prdata = rdata_r;

endmodule

// ---- core_model.sv ----
// core-side model: pulses context events and timer-5 events on request.
// assumes the bench calls its tasks; outputs change just after clk edges.
`timescale 1ns/1ps
module core_model
    import ctrl_regs_pkg::*;
(
    input  wire logic clk,
    output ctx_event_type ctx_event,
    output t5_event_type  t5_event
);
    initial begin
        ctx_event = '0;
        t5_event  = '0;
    end
    // one-cycle pulse, as the core raises it on handler entry or return
    task ctx(input ctx_event_type e);
        @(posedge clk);
        ctx_event <= e;
        @(posedge clk);
        ctx_event <= '0;
    endtask
    // event level held n cycles; lets a set overlap a software clear
    task t5(input t5_event_type e, input int n);
        @(posedge clk);
        t5_event <= e;
        repeat (n) @(posedge clk);
        t5_event <= '0;
    endtask
endmodule

// ---- ctrl_regs_monitor.sv ----
// checker for the state and flag register block, bound to its top ports.
// assumes one clock domain and the zero-wait apb slave of the block.
`timescale 1ns/1ps
module ctrl_regs_monitor
    import ctrl_regs_pkg::*;
(
    input wire logic          clk,
    input wire logic          resetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [15:0]   paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire ctx_event_type ctx_event,
    input wire t5_event_type  t5_event,
    input wire ctx_type       exec_state,
    input wire logic          timer5_gate_event_flag,
    input wire logic          timer5_count_event_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire acc = psel && penable;
    ////////////////////////////////////////////////////////////////////////
    a_window_err: assert property (acc |-> pslverr == (paddr[15:2] < WINDOW_LOW))
        else $error("window error flag wrong");
    a_state_read: assert property (acc && !pwrite && paddr[15:2] == EXEC_STATE_INDEX
        |-> prdata[7:6] == $past(exec_state)) else $error("state read wrong");
    a_unused_zero: assert property (acc && !pwrite |-> prdata[5:0] == 0 && prdata[31:8] == 0)
        else $error("unused bits not zero");
    a_state_quiet: assert property (ctx_event == 3'b000 |=> $stable(exec_state))
        else $error("state moved without event");
    a_high_main: assert property (ctx_event.high_entry && exec_state == CTX_MAIN
        |=> exec_state == CTX_HIGH_MAIN) else $error("high from main wrong");
    a_low_main: assert property (ctx_event == 3'b010 && exec_state == CTX_MAIN
        |=> exec_state == CTX_LOW) else $error("low from main wrong");
    a_return_low: assert property (ctx_event == 3'b001 && exec_state == CTX_HIGH_LOW
        |=> exec_state == CTX_LOW) else $error("return to low wrong");
    a_gate_set: assert property (t5_event.gate_event |=> timer5_gate_event_flag)
        else $error("gate flag not set");
    a_count_set: assert property (t5_event.count_event |=> timer5_count_event_flag)
        else $error("count flag not set");
    a_flag_hold: assert property (timer5_gate_event_flag && !(acc && pwrite)
        |=> timer5_gate_event_flag) else $error("gate flag lost");
    a_count_hold: assert property (timer5_count_event_flag && !(acc && pwrite)
        |=> timer5_count_event_flag) else $error("count flag lost");
endmodule
bind interrupt_state_and_flag_regs ctrl_regs_monitor mon_u (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pslverr, .ctx_event, .t5_event, .exec_state,
    .timer5_gate_event_flag, .timer5_count_event_flag);

// ---- testbench.sv ----
// self-checking bench: apb reads and writes plus core event pulses.
// assumes zero-wait apb slave at byte address = 4 * register index.
`timescale 1ns/1ps
module testbench;
    import ctrl_regs_pkg::*;
    logic          clk, resetn, psel, penable, pwrite, pready, pslverr, gflag, cflag;
    logic [15:0]   paddr;
    logic [31:0]   pwdata, prdata;
    ctx_event_type cev;
    t5_event_type  tev;
    ctx_type       st;
    int            error_cnt, checks_done, cyc;
    logic [2:0]    evs [6] = '{3'b010, 3'b100, 3'b001, 3'b001, 3'b100, 3'b001};
    logic [7:0]    exps [6] = '{8'h40, 8'hC0, 8'h40, 8'h00, 8'h80, 8'h00};
    interrupt_state_and_flag_regs dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .ctx_event(cev), .t5_event(tev),
        .exec_state(st), .timer5_gate_event_flag(gflag), .timer5_count_event_flag(cflag));
    core_model core_u (.clk, .ctx_event(cev), .t5_event(tev));
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // two-bit compare of a level output, looked at once it has settled
    task cmp2(input string n, input logic [1:0] x, input logic [1:0] g);
        checks_done++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    // e holds {expected error, expected byte}; reads only are compared
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [8:0] e);
        logic [32:0] x;
        x = {e[8], 24'h0, e[7:0]};
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        if (!w) begin
            checks_done++;
            if ({pslverr, prdata} !== x) begin
                error_cnt++;
                $display("[ERR] reg %h exp %h got %h", a, x, {pslverr, prdata});
            end
        end
        psel <= 0;
        penable <= 0;
    endtask
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report;
        end
    end
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge clk);
        resetn <= 1;
        apb(0, 16'hFFC0, 0, 9'h000);
        apb(0, 16'hFFC4, 0, 9'h000);
        apb(1, 16'hFFC0, 8'hFF, 0);
        apb(0, 16'hFFC0, 0, 9'h000);
        apb(1, 16'hE000, 8'hFF, 0);
        apb(0, 16'hE000, 0, 9'h000);
        apb(0, 16'hDFFC, 0, 9'h100);
        apb(0, 16'hFFFC, 0, 9'h000);
        for (int i = 0; i < 6; i++) begin
            core_u.ctx(evs[i]);
            apb(0, 16'hFFC0, 0, {1'b0, exps[i]});
            cmp2("exec_state", exps[i][7:6], st);
        end
        core_u.t5(2'b10, 1);
        apb(0, 16'hFFC4, 0, 9'h080);
        cmp2("t5 flags", 2'b10, {gflag, cflag});
        core_u.t5(2'b01, 1);
        apb(0, 16'hFFC4, 0, 9'h0C0);
        cmp2("t5 flags", 2'b11, {gflag, cflag});
        apb(1, 16'hFFC4, 8'h80, 0);
        apb(0, 16'hFFC4, 0, 9'h080);
        // count event sampled at the very edge that takes the clearing write
        fork
            core_u.t5(2'b01, 2);
            apb(1, 16'hFFC4, 8'h00, 0);
        join
        apb(0, 16'hFFC4, 0, 9'h040);
        cmp2("t5 flags", 2'b01, {gflag, cflag});
        apb(1, 16'hFFC4, 8'h00, 0);
        apb(0, 16'hFFC4, 0, 9'h000);
        cmp2("t5 flags", 2'b00, {gflag, cflag});
        // bring-up force register: sets both flags, itself reads zero
        apb(1, 16'hFFC8, 8'hC0, 0);
        apb(0, 16'hFFC8, 0, 9'h000);
        apb(0, 16'hFFC4, 0, 9'h0C0);
        cmp2("t5 flags", 2'b11, {gflag, cflag});
        apb(1, 16'hFFC4, 8'h00, 0);
        apb(0, 16'hFFC4, 0, 9'h000);
        cmp2("t5 flags", 2'b00, {gflag, cflag});
        final_report;
    end
endmodule
